// *** src/sdpa_regs.sv ***
`timescale 1ns/1ps
// Functional notes
// (RQ1) Odd-field copy-generation insertion enabled only by control register bit 5.
// (RQ2) Even-field insertion enabled by bit 6, independent of odd-field enable.
// (RQ3) Mid register: bits 5:0 payload 13..8, bits 7:6 copy-gen bits 15..14.
// (RQ4) Low register holds payload bits 7..0 for either service.
// (RQ5) Luma scale is 10 bits: upper eight from luma register, low two LSB 1:0.
// (RQ6) Blue difference scale: upper from blue register, low two from LSB 3:2.
// (RQ7) Red difference scale: upper from red register, low two from LSB 5:4.
// (RQ8) Hue adjust takes all eight bits of the hue register.
// (RQ9) Anti-alias gain nibble 0/6/C = -4/0/+4 dB, only when filter enabled.
// (RQ10) Coring gain codes 0..8, +1/16 per step, -1/8 in noise-reduction mode.
// (RQ11) Noise reduction: threshold, area, block size, input, mode, block offset.
// (RQ12) Control bit 4 CRC enable, bit 7 wide-screen enable; brightness bit 7 blanks.
module sdpa_regs (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wr_en,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_aa_filt_en,
   output logic [7:0] o_rdata,
   output logic o_cg_odd_en,
   output logic o_cg_even_en,
   output logic o_cg_crc_en,
   output logic o_ws_en,
   output logic o_ws_blank,
   output logic [19:0] o_cg_payload,
   output logic [9:0] o_luma_scale,
   output logic [9:0] o_blue_colour_difference_scale,
   output logic [9:0] o_red_colour_difference_scale,
   output logic [1:0] o_phase_lsb,
   output logic [7:0] o_hue,
   output logic [6:0] o_brightness,
   output logic o_aa_gain_valid,
   output logic [3:0] o_luma_antialias_filter_gain,
   output logic [3:0] o_coring_border,
   output logic [3:0] o_coring_data,
   output logic [5:0] o_nr_threshold,
   output logic o_nr_area_4px,
   output logic o_nr_block_16px,
   output logic [2:0] o_nr_input_sel,
   output logic o_nr_sharp_mode,
   output logic [3:0] o_nr_block_offset
);
   logic rst_s1_q;
   logic rst_n_q;
   logic [7:0] cg_ctrl_q, cg_mid_q, cg_low_q, scale_lsb_q, luma_q, blue_q, red_q;
   logic [7:0] hue_q, bright_q, aa_q, coring_q, thresh_q, mode_q;
   logic [7:0] rdata_d;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // Register writes over the serial control port
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cg_ctrl_q <= sdpa_pkg::RESET_VAL;
         cg_mid_q <= sdpa_pkg::RESET_VAL;
         cg_low_q <= sdpa_pkg::RESET_VAL;
         scale_lsb_q <= sdpa_pkg::RESET_VAL;
         luma_q <= sdpa_pkg::RESET_VAL;
         blue_q <= sdpa_pkg::RESET_VAL;
         red_q <= sdpa_pkg::RESET_VAL;
         hue_q <= sdpa_pkg::RESET_VAL;
         bright_q <= sdpa_pkg::RESET_VAL;
         aa_q <= sdpa_pkg::RESET_VAL;
         coring_q <= sdpa_pkg::RESET_VAL;
         thresh_q <= sdpa_pkg::RESET_VAL;
         mode_q <= sdpa_pkg::RESET_VAL;
      end else if (i_wr_en) begin
         case (i_addr)
            sdpa_pkg::ADDR_CG_CTRL: cg_ctrl_q <= i_wdata; // [RQ1] [RQ2] [RQ12]
            sdpa_pkg::ADDR_CG_MID: cg_mid_q <= i_wdata; // [RQ3]
            sdpa_pkg::ADDR_CG_LOW: cg_low_q <= i_wdata; // [RQ4]
            sdpa_pkg::ADDR_SCALE_LSB: scale_lsb_q <= i_wdata;
            sdpa_pkg::ADDR_LUMA_SCALE: luma_q <= i_wdata;
            sdpa_pkg::ADDR_BLUE_SCALE: blue_q <= i_wdata;
            sdpa_pkg::ADDR_RED_SCALE: red_q <= i_wdata;
            sdpa_pkg::ADDR_HUE: hue_q <= i_wdata; // [RQ8]
            sdpa_pkg::ADDR_BRIGHT: bright_q <= i_wdata; // [RQ12]
            sdpa_pkg::ADDR_AA_GAIN: aa_q <= i_wdata & sdpa_pkg::AA_GAIN_MASK; // [RQ9]
            sdpa_pkg::ADDR_NR_CORING: coring_q <= i_wdata; // [RQ10]
            sdpa_pkg::ADDR_NR_THRESH: thresh_q <= i_wdata; // [RQ11]
            sdpa_pkg::ADDR_NR_MODE: mode_q <= i_wdata; // [RQ11]
            default: ;
         endcase
      end
   end

   // Readback; unmapped subaddresses read zero
   always_comb begin
      case (i_addr)
         sdpa_pkg::ADDR_CG_CTRL: rdata_d = cg_ctrl_q;
         sdpa_pkg::ADDR_CG_MID: rdata_d = cg_mid_q;
         sdpa_pkg::ADDR_CG_LOW: rdata_d = cg_low_q;
         sdpa_pkg::ADDR_SCALE_LSB: rdata_d = scale_lsb_q;
         sdpa_pkg::ADDR_LUMA_SCALE: rdata_d = luma_q;
         sdpa_pkg::ADDR_BLUE_SCALE: rdata_d = blue_q;
         sdpa_pkg::ADDR_RED_SCALE: rdata_d = red_q;
         sdpa_pkg::ADDR_HUE: rdata_d = hue_q;
         sdpa_pkg::ADDR_BRIGHT: rdata_d = bright_q;
         sdpa_pkg::ADDR_AA_GAIN: rdata_d = aa_q;
         sdpa_pkg::ADDR_NR_CORING: rdata_d = coring_q;
         sdpa_pkg::ADDR_NR_THRESH: rdata_d = thresh_q;
         sdpa_pkg::ADDR_NR_MODE: rdata_d = mode_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= rdata_d;
      end
   end

   // Copy-generation and wide-screen flags
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_cg_odd_en <= 1'b0;
         o_cg_even_en <= 1'b0;
         o_cg_crc_en <= 1'b0;
         o_ws_en <= 1'b0;
         o_ws_blank <= 1'b0;
      end else begin
         o_cg_odd_en <= cg_ctrl_q[sdpa_pkg::CG_ODD_BIT]; // [RQ1]
         o_cg_even_en <= cg_ctrl_q[sdpa_pkg::CG_EVEN_BIT]; // [RQ2]
         o_cg_crc_en <= cg_ctrl_q[sdpa_pkg::CG_CRC_BIT]; // [RQ12]
         o_ws_en <= cg_ctrl_q[sdpa_pkg::WS_EN_BIT]; // [RQ12]
         o_ws_blank <= bright_q[sdpa_pkg::WS_BLANK_BIT]; // [RQ12]
      end
   end

   // Copy-generation or wide-screen payload
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_cg_payload <= 20'h00000;
      end else begin
         o_cg_payload <= {cg_ctrl_q[3:0], cg_mid_q, cg_low_q}; // [RQ3] [RQ4]
      end
   end

   // Ten-bit scale factors and the phase low bits
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_luma_scale <= 10'h000;
         o_blue_colour_difference_scale <= 10'h000;
         o_red_colour_difference_scale <= 10'h000;
         o_phase_lsb <= 2'h0;
      end else begin
         o_luma_scale <= {luma_q, scale_lsb_q[1:0]}; // [RQ5]
         o_blue_colour_difference_scale <= {blue_q, scale_lsb_q[3:2]}; // [RQ6]
         o_red_colour_difference_scale <= {red_q, scale_lsb_q[5:4]}; // [RQ7]
         o_phase_lsb <= scale_lsb_q[7:6];
      end
   end

   // Hue and brightness
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_hue <= 8'h00;
         o_brightness <= 7'h00;
      end else begin
         o_hue <= hue_q; // [RQ8]
         o_brightness <= bright_q[6:0]; // [RQ12]
      end
   end

   // Anti-alias gain; 0 dB stands while the filter is off, in reset too
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_aa_gain_valid <= 1'b0;
         o_luma_antialias_filter_gain <= sdpa_pkg::AA_GAIN_0DB;
      end else begin
         o_aa_gain_valid <= i_aa_filt_en; // [RQ9]
         o_luma_antialias_filter_gain <= i_aa_filt_en ? aa_q[3:0] :
                                         sdpa_pkg::AA_GAIN_0DB; // [RQ9]
      end
   end

   // Coring gains; codes above 8 are clamped to the largest defined step
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_coring_border <= 4'h0;
         o_coring_data <= 4'h0;
      end else begin
         o_coring_border <= (coring_q[3:0] > sdpa_pkg::CORING_MAX) ?
                            sdpa_pkg::CORING_MAX : coring_q[3:0]; // [RQ10]
         o_coring_data <= (coring_q[7:4] > sdpa_pkg::CORING_MAX) ?
                          sdpa_pkg::CORING_MAX : coring_q[7:4]; // [RQ10]
      end
   end

   // Noise-reduction threshold, area, block size, input, mode and offset
   always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_nr_threshold <= 6'h00;
         o_nr_area_4px <= 1'b0;
         o_nr_block_16px <= 1'b0;
         o_nr_input_sel <= 3'h0;
         o_nr_sharp_mode <= 1'b0;
         o_nr_block_offset <= 4'h0;
      end else begin
         o_nr_threshold <= thresh_q[5:0]; // [RQ11]
         o_nr_area_4px <= thresh_q[sdpa_pkg::NR_AREA_BIT]; // [RQ11]
         o_nr_block_16px <= thresh_q[sdpa_pkg::NR_BSIZE_BIT]; // [RQ11]
         o_nr_input_sel <= mode_q[2:0]; // [RQ11]
         o_nr_sharp_mode <= mode_q[sdpa_pkg::NR_MODE_BIT]; // [RQ10] [RQ11]
         o_nr_block_offset <= mode_q[7:4]; // [RQ11]
      end
   end

   a_odd_enable: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ1]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL |=> ##1 o_cg_odd_en == $past(i_wdata[5], 2))
      else $error("odd-field enable mismatch");
   a_even_enable: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ2]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL |=> ##1 o_cg_even_en == $past(i_wdata[6], 2))
      else $error("even-field enable mismatch");
   a_mid_payload: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ3]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_MID |=> ##1 o_cg_payload[15:8] == $past(i_wdata, 2))
      else $error("mid payload mismatch");
   a_low_payload: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ4]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_LOW |=> ##1 o_cg_payload[7:0] == $past(i_wdata, 2))
      else $error("low payload mismatch");
   a_luma_scale: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ5]
      i_wr_en && i_addr == sdpa_pkg::ADDR_LUMA_SCALE |=> ##1 o_luma_scale[9:2] == $past(i_wdata, 2))
      else $error("luma scale mismatch");
   a_lsb_split: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ6] [RQ7]
      i_wr_en && i_addr == sdpa_pkg::ADDR_SCALE_LSB |=> ##1
      o_blue_colour_difference_scale[1:0] == $past(i_wdata[3:2], 2) &&
      o_red_colour_difference_scale[1:0] == $past(i_wdata[5:4], 2))
      else $error("scale low bits mismatch");
   a_hue_value: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ8]
      i_wr_en && i_addr == sdpa_pkg::ADDR_HUE |=> ##1 o_hue == $past(i_wdata, 2))
      else $error("hue mismatch");
   a_aa_disabled: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ9]
      !i_aa_filt_en |=> o_luma_antialias_filter_gain == sdpa_pkg::AA_GAIN_0DB && !o_aa_gain_valid)
      else $error("gain applied while filter off");
   a_coring_range: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ10]
      o_coring_border <= sdpa_pkg::CORING_MAX && o_coring_data <= sdpa_pkg::CORING_MAX)
      else $error("coring code out of range");
   a_nr_offset: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_MODE |=> ##1 o_nr_block_offset == $past(i_wdata[7:4], 2))
      else $error("block offset mismatch");
   a_ws_blank: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ12]
      i_wr_en && i_addr == sdpa_pkg::ADDR_BRIGHT |=> ##1 o_ws_blank == $past(i_wdata[7], 2))
      else $error("blank bit mismatch");

   // Field decode checks
   a_crc_enable: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ12]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL |=> ##1 o_cg_crc_en == $past(i_wdata[4], 2))
      else $error("CRC enable mismatch");
   a_ws_enable: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ12]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL |=> ##1 o_ws_en == $past(i_wdata[7], 2))
      else $error("wide-screen enable mismatch");
   a_field_indep: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ2]
      i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL && i_wdata[5] != i_wdata[6] |=> ##1
      o_cg_odd_en != o_cg_even_en)
      else $error("odd and even enables not independent");
   a_luma_low: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ5]
      i_wr_en && i_addr == sdpa_pkg::ADDR_SCALE_LSB |=> ##1
      o_luma_scale[1:0] == $past(i_wdata[1:0], 2))
      else $error("luma scale low bits mismatch");
   a_blue_upper: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ6]
      i_wr_en && i_addr == sdpa_pkg::ADDR_BLUE_SCALE |=> ##1
      o_blue_colour_difference_scale[9:2] == $past(i_wdata, 2))
      else $error("blue scale mismatch");
   a_red_upper: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ7]
      i_wr_en && i_addr == sdpa_pkg::ADDR_RED_SCALE |=> ##1
      o_red_colour_difference_scale[9:2] == $past(i_wdata, 2))
      else $error("red scale mismatch");
   a_bright_value: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ12]
      i_wr_en && i_addr == sdpa_pkg::ADDR_BRIGHT |=> ##1 o_brightness == $past(i_wdata[6:0], 2))
      else $error("brightness mismatch");
   a_aa_enabled: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ9]
      i_aa_filt_en && o_aa_gain_valid |=> o_luma_antialias_filter_gain == $past(aa_q[3:0]))
      else $error("gain not applied while filter on");
   a_aa_reserved: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ9]
      aa_q[7:4] == 4'h0)
      else $error("reserved gain bits set");
   a_border_pass: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ10]
      coring_q[3:0] <= sdpa_pkg::CORING_MAX |=> o_coring_border == $past(coring_q[3:0]))
      else $error("border coring code mismatch");
   a_data_pass: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ10]
      coring_q[7:4] <= sdpa_pkg::CORING_MAX |=> o_coring_data == $past(coring_q[7:4]))
      else $error("data coring code mismatch");
   a_nr_threshold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_THRESH |=> ##1
      o_nr_threshold == $past(i_wdata[5:0], 2))
      else $error("threshold mismatch");
   a_nr_area: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_THRESH |=> ##1
      o_nr_area_4px == $past(i_wdata[6], 2))
      else $error("border area mismatch");
   a_nr_bsize: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_THRESH |=> ##1
      o_nr_block_16px == $past(i_wdata[7], 2))
      else $error("block size mismatch");
   a_nr_input: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_MODE |=> ##1
      o_nr_input_sel == $past(i_wdata[2:0], 2))
      else $error("input select mismatch");
   a_nr_mode: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      i_wr_en && i_addr == sdpa_pkg::ADDR_NR_MODE |=> ##1
      o_nr_sharp_mode == $past(i_wdata[4], 2))
      else $error("sharpness mode mismatch");

   // Readback checks
   a_ctrl_read: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ1]
      i_addr == sdpa_pkg::ADDR_CG_CTRL |=> o_rdata == $past(cg_ctrl_q))
      else $error("control readback mismatch");
   a_mid_read: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ3]
      i_addr == sdpa_pkg::ADDR_CG_MID |=> o_rdata == $past(cg_mid_q))
      else $error("mid readback mismatch");
   a_low_read: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ4]
      i_addr == sdpa_pkg::ADDR_CG_LOW |=> o_rdata == $past(cg_low_q))
      else $error("low readback mismatch");
   a_hue_read: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ8]
      i_addr == sdpa_pkg::ADDR_HUE |=> o_rdata == $past(hue_q))
      else $error("hue readback mismatch");
   a_aa_read: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ9]
      i_addr == sdpa_pkg::ADDR_AA_GAIN |=> o_rdata[7:4] == 4'h0)
      else $error("reserved gain bits read back set");

   // Registers hold when not written
   a_ctrl_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ1]
      !(i_wr_en && i_addr == sdpa_pkg::ADDR_CG_CTRL) |=> $stable(cg_ctrl_q))
      else $error("control register changed without write");
   a_scale_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ5]
      !(i_wr_en && i_addr == sdpa_pkg::ADDR_SCALE_LSB) |=> $stable(scale_lsb_q))
      else $error("scale register changed without write");
   a_hue_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ8]
      !(i_wr_en && i_addr == sdpa_pkg::ADDR_HUE) |=> $stable(hue_q))
      else $error("hue register changed without write");
   a_coring_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ10]
      !(i_wr_en && i_addr == sdpa_pkg::ADDR_NR_CORING) |=> $stable(coring_q))
      else $error("coring register changed without write");
   a_mode_hold: assert property (@(posedge i_clk) disable iff (!rst_n_q) // [RQ11]
      !(i_wr_en && i_addr == sdpa_pkg::ADDR_NR_MODE) |=> $stable(mode_q))
      else $error("mode register changed without write");

   c_both_fields: cover property (@(posedge i_clk) disable iff (!rst_n_q)
      o_cg_odd_en && o_cg_even_en);
   c_sharp_mode: cover property (@(posedge i_clk) disable iff (!rst_n_q)
      o_nr_sharp_mode && o_coring_data == sdpa_pkg::CORING_MAX);
   c_aa_boost: cover property (@(posedge i_clk) disable iff (!rst_n_q)
      o_aa_gain_valid && o_luma_antialias_filter_gain == sdpa_pkg::AA_GAIN_P4DB);
   c_back_to_back: cover property (@(posedge i_clk) disable iff (!rst_n_q)
      i_wr_en ##1 i_wr_en);
   c_coring_clamp: cover property (@(posedge i_clk) disable iff (!rst_n_q)
      coring_q[3:0] > sdpa_pkg::CORING_MAX && o_coring_border == sdpa_pkg::CORING_MAX);
endmodule // sdpa_regs

// *** src/sdpa_pkg.sv ***
package sdpa_pkg;
   // Subaddresses
   localparam logic [7:0] ADDR_CG_CTRL = 8'h99;
   localparam logic [7:0] ADDR_CG_MID = 8'h9A;
   localparam logic [7:0] ADDR_CG_LOW = 8'h9B;
   localparam logic [7:0] ADDR_SCALE_LSB = 8'h9C;
   localparam logic [7:0] ADDR_LUMA_SCALE = 8'h9D;
   localparam logic [7:0] ADDR_BLUE_SCALE = 8'h9E;
   localparam logic [7:0] ADDR_RED_SCALE = 8'h9F;
   localparam logic [7:0] ADDR_HUE = 8'hA0;
   localparam logic [7:0] ADDR_BRIGHT = 8'hA1;
   localparam logic [7:0] ADDR_AA_GAIN = 8'hA2;
   localparam logic [7:0] ADDR_NR_CORING = 8'hA3;
   localparam logic [7:0] ADDR_NR_THRESH = 8'hA4;
   localparam logic [7:0] ADDR_NR_MODE = 8'hA5;
   localparam logic [7:0] RESET_VAL = 8'h00;
   // Field positions
   localparam int CG_CRC_BIT = 4;
   localparam int CG_ODD_BIT = 5;
   localparam int CG_EVEN_BIT = 6;
   localparam int WS_EN_BIT = 7;
   localparam int WS_BLANK_BIT = 7;
   localparam int AA_FILT_EN_BIT = 4;
   localparam int NR_MODE_BIT = 4;
   localparam int NR_AREA_BIT = 6;
   localparam int NR_BSIZE_BIT = 7;
   // Write mask for the anti-alias gain register: upper nibble reserved
   localparam logic [7:0] AA_GAIN_MASK = 8'h0F;
   localparam logic [3:0] AA_GAIN_M4DB = 4'h0;
   localparam logic [3:0] AA_GAIN_0DB = 4'h6;
   localparam logic [3:0] AA_GAIN_P4DB = 4'hC;
   localparam logic [3:0] CORING_MAX = 4'h8;
   localparam int NUM_REGS = 13;
endpackage

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic i_clk, i_rst_n, i_wr_en, i_aa_filt_en;
   logic [7:0] i_addr, i_wdata, o_rdata, o_hue;
   logic o_cg_odd_en, o_cg_even_en, o_cg_crc_en, o_ws_en, o_ws_blank, o_aa_gain_valid;
   logic [19:0] o_cg_payload;
   logic [9:0] o_luma_scale, o_blue_colour_difference_scale, o_red_colour_difference_scale;
   logic [1:0] o_phase_lsb;
   logic [6:0] o_brightness;
   logic [3:0] o_luma_antialias_filter_gain, o_coring_border, o_coring_data, o_nr_block_offset;
   logic [5:0] o_nr_threshold;
   logic o_nr_area_4px, o_nr_block_16px, o_nr_sharp_mode;
   logic [2:0] o_nr_input_sel;
   logic [7:0] mem [0:255];
   int num_errors, checks;

   sdpa_regs dut (.i_clk, .i_rst_n, .i_wr_en, .i_addr, .i_wdata, .i_aa_filt_en, .o_rdata,
      .o_cg_odd_en, .o_cg_even_en, .o_cg_crc_en, .o_ws_en, .o_ws_blank, .o_cg_payload,
      .o_luma_scale, .o_blue_colour_difference_scale, .o_red_colour_difference_scale,
      .o_phase_lsb, .o_hue, .o_brightness, .o_aa_gain_valid, .o_luma_antialias_filter_gain,
      .o_coring_border, .o_coring_data, .o_nr_threshold, .o_nr_area_4px, .o_nr_block_16px,
      .o_nr_input_sel, .o_nr_sharp_mode, .o_nr_block_offset);

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   function automatic logic [3:0] clamp(input logic [3:0] v);
      return (v > 4'h8) ? 4'h8 : v;
   endfunction

   // Model write: unmapped places ignored, reserved gain nibble stays 0
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_wr_en = 1'b1;
      i_addr = a;
      i_wdata = d;
      if (a >= 8'h99 && a <= 8'hA5) begin
         mem[a] = (a == 8'hA2) ? (d & 8'h0F) : d;
      end
   endtask

   task automatic settle();
      @(negedge i_clk);
      i_wr_en = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask

   task automatic check_all();
      logic [7:0] s;
      s = mem[8'h9C];
      chk(o_cg_odd_en, mem[8'h99][5]);
      chk(o_cg_even_en, mem[8'h99][6]);
      chk(o_cg_payload, {mem[8'h99][3:0], mem[8'h9A], mem[8'h9B]});
      chk(o_luma_scale, {mem[8'h9D], s[1:0]});
      chk(o_blue_colour_difference_scale, {mem[8'h9E], s[3:2]});
      chk(o_red_colour_difference_scale, {mem[8'h9F], s[5:4]});
      chk(o_phase_lsb, s[7:6]);
      chk(o_hue, mem[8'hA0]);
      chk(o_aa_gain_valid, i_aa_filt_en);
      chk(o_luma_antialias_filter_gain, i_aa_filt_en ? mem[8'hA2][3:0] : 4'h6);
      chk(o_coring_border, clamp(mem[8'hA3][3:0]));
      chk(o_coring_data, clamp(mem[8'hA3][7:4]));
      chk({o_nr_block_16px, o_nr_area_4px, o_nr_threshold}, mem[8'hA4]);
      chk({o_nr_block_offset, o_nr_sharp_mode, o_nr_input_sel},
         {mem[8'hA5][7:4], mem[8'hA5][4], mem[8'hA5][2:0]});
      chk({o_ws_en, o_cg_crc_en}, {mem[8'h99][7], mem[8'h99][4]});
      chk({o_ws_blank, o_brightness}, mem[8'hA1]);
   endtask

   // Readback of the whole block plus one unmapped place on each side
   task automatic readback();
      for (int a = 8'h98; a <= 8'hA6; a++) begin
         @(negedge i_clk);
         i_addr = 8'(a);
         @(negedge i_clk);
         chk(o_rdata, mem[a]);
      end
   endtask

   task automatic wrap_up();
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      i_rst_n = 1'b0;
      i_wr_en = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_aa_filt_en = 1'b0;
      num_errors = 0;
      checks = 0;
      foreach (mem[i]) mem[i] = 8'h00;
      void'($urandom(32'h203C7C10));
      repeat (4) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk);
      check_all();
      readback();
      // Every gain and coring code, with the filter on for even gain codes and off for odd
      for (int k = 0; k < 16; k++) begin
         i_aa_filt_en = ~k[0];
         wr(8'hA2, 8'hF0 | 8'(k));
         wr(8'hA3, {4'(k), 4'hF - 4'(k)});
         settle();
         check_all();
      end
      // Random bursts, back to back, unmapped places included
      for (int n = 0; n < 80; n++) begin
         i_aa_filt_en = 1'($urandom);
         repeat (1 + $urandom % 3) wr(8'h98 + 8'($urandom % 15), 8'($urandom));
         settle();
         check_all();
      end
      readback();
      // Reset in mid-run returns every register to zero
      i_rst_n = 1'b0;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (2) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_clk);
      check_all();
      readback();
      wrap_up();
   end
endmodule // testbench
